// *** iis_bus_peer.sv ***
`timescale 1ns/10ps
// ====
// Remote bus party: turns bench commands into engine events
module iis_bus_peer
  import iis_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic go, // Issue event
  input wire logic [2:0] kind, // Event bit index
  input wire logic [7:0] byte_in, // Payload
  output iis_evt_t evt, // Event pulses
  output logic [15:0] abort_cause_in, // Abort cause
  output logic [7:0] rx_byte, // Byte after general call
  output logic rx_byte_valid // Byte strobe
);
  initial
  begin
    evt = '0;
    abort_cause_in = 16'h0000;
    rx_byte = 8'h00;
    rx_byte_valid = 1'h0;
  end
  // Idle data flips each cycle so stale values never look fresh
  always @(posedge ref_clk)
  begin
    evt <= iis_evt_t'(go ? 7'h01 << kind : 7'h00);
    abort_cause_in <= go ? {8'h00, byte_in} : ~abort_cause_in;
    rx_byte_valid <= evt.gen_call_ack;
    rx_byte <= evt.gen_call_ack ? byte_in : ~rx_byte;
  end
endmodule

// *** iis_cfg.svh ***
`ifndef IIS_CFG_SVH
`define IIS_CFG_SVH

// Register byte address of the masked status register
`define IIS_STAT_ADDR 32'h5000_132C
// Status bit positions
`define IIS_B_GEN_CALL 11
`define IIS_B_START 10
`define IIS_B_STOP 9
`define IIS_B_ACTIVITY 8
`define IIS_B_TX_DONE 7
`define IIS_B_TX_ABORT 6
`define IIS_B_RD_REQ 5
`define IIS_B_TX_EMPTY 4
`define IIS_B_TX_OVER 3
// Reset values
`define IIS_STAT_RESET 16'h0000
`define IIS_FLAGS_RESET 9'h000
// Transmit FIFO geometry
`define IIS_TXF_DEPTH 32
`define IIS_TXF_LVL_W 6
`define IIS_TXF_FULL 6'h20
`define IIS_TXF_ZERO 6'h00
`define IIS_TXF_ONE 6'h01
`define IIS_ABRT_W 16
`define IIS_ABRT_RESET 16'h0000

`endif

// *** iis_enable_ctl.sv ***
`timescale 1ns/10ps
`include "iis_cfg.svh"

// Tracks the internal enable: it only falls once the state machines are idle
module iis_enable_ctl
  import iis_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic enable_bit, // Bit 0 of the enable register
  input wire logic fsm_active, // Master or slave machine busy
  output logic internal_enable_state // Internal enable
);

  iis_en_state_t state_reg;
  iis_en_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      IIS_RUN:
        if (!enable_bit)
          state_next = IIS_DRAIN;
      IIS_DRAIN:
        if (enable_bit)
          state_next = IIS_RUN;
        else if (!fsm_active)
          state_next = IIS_OFF;
      IIS_OFF:
        if (enable_bit)
          state_next = IIS_RUN;
      default:
        state_next = IIS_OFF;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      state_reg <= IIS_OFF;
    else
      state_reg <= state_next;
  end

  assign internal_enable_state = (state_reg != IIS_OFF);

endmodule

// *** iis_intr_status.sv ***
`timescale 1ns/10ps
`include "iis_cfg.svh"

module iis_intr_status
  import iis_pkg::*;
(
  input wire logic ref_clk, // Clock, 100 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic controller_enable_reg, // Enable register bit 0
  input wire logic fsm_active, // Master or slave machine busy
  input iis_evt_t evt, // Serial engine event pulses
  input wire logic [`IIS_ABRT_W-1:0] abort_cause_in, // Cause bits with the abort pulse
  input iis_clr_t clr_rd, // Clear register read strobes
  input wire logic data_command_port_wr, // Processor write to data port
  input wire logic [7:0] rx_byte, // Byte received from bus
  input wire logic rx_byte_valid, // Received byte strobe
  input wire logic txf_pop, // Serial engine takes a FIFO entry
  input wire logic [`IIS_TXF_LVL_W-1:0] transmit_threshold_reg, // Transmit threshold
  input wire logic [15:0] intr_mask, // Interrupt mask register
  input wire logic stat_rd, // Read strobe of status register
  output logic [15:0] masked_interrupt_status, // Status read data
  output logic [`IIS_ABRT_W-1:0] abort_cause_reg, // Abort cause register
  output logic txf_accept, // Data port write accepted
  output logic scl_hold_low, // Stretch SCL while high
  output logic [7:0] rxb_data, // Byte forwarded to receive buffer
  output logic rxb_push, // Receive buffer write strobe
  output logic intr_req // Combined interrupt request
);

  // ==========================================================
  // Enable tracking and FIFO level
  // ==========================================================
  logic internal_enable_state;
  logic [`IIS_TXF_LVL_W-1:0] txf_level;
  iis_flags_t flags_reg;
  iis_flags_t flags_next;
  logic abort_lock_reg;
  logic abort_lock_next;
  logic [`IIS_ABRT_W-1:0] cause_reg;
  logic [`IIS_ABRT_W-1:0] cause_next;
  logic [15:0] stat_reg;
  logic [7:0] rxb_data_reg;
  logic rxb_push_reg;
  logic gc_rx_reg;
  logic gc_rx_next;

  iis_enable_ctl u_en (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .enable_bit(controller_enable_reg),
    .fsm_active(fsm_active),
    .internal_enable_state(internal_enable_state)
  );

  // Abort sets flush immediately so a racing write cannot slip in
  wire txf_flush = !controller_enable_reg || abort_lock_reg || evt.tx_abort;
  wire txf_full = (txf_level == `IIS_TXF_FULL);
  wire wr_ok = data_command_port_wr && !txf_flush && !txf_full;

  iis_txf_level u_lvl (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .flush(txf_flush),
    .push(wr_ok),
    .pop(txf_pop),
    .level(txf_level)
  );

  assign txf_accept = wr_ok;

  // ==========================================================
  // Set and clear terms
  // ==========================================================
  // Disabling clears sticky flags except rd_req, and tx_over only once the internal enable is off; pending sets still win that cycle
  wire dis = !controller_enable_reg;
  wire ovr_evt = data_command_port_wr && txf_full && controller_enable_reg;

  // Level-style empty: threshold compare while enabled, activity while off
  wire empty_lvl = controller_enable_reg ? (txf_level <= transmit_threshold_reg) : fsm_active;

  always_comb
  begin
    flags_next = flags_reg;
    flags_next.gen_call = evt.gen_call_ack || (flags_reg.gen_call && !dis && !clr_rd.gen_call);
    flags_next.start_seen = evt.start_seen || (flags_reg.start_seen && !clr_rd.all && !dis);
    flags_next.stop_seen = evt.stop_seen || (flags_reg.stop_seen && !clr_rd.all && !dis);
    flags_next.activity = evt.activity ||
      (flags_reg.activity && !dis && !clr_rd.activity && !clr_rd.all);
    flags_next.tx_done = evt.slv_tx_nack || (flags_reg.tx_done && !clr_rd.all && !dis);
    flags_next.tx_abort = evt.tx_abort ||
      (flags_reg.tx_abort && !clr_rd.tx_abort && !clr_rd.all && !dis);
    flags_next.rd_req = evt.rd_req || (flags_reg.rd_req && !clr_rd.rd_req && !clr_rd.all);
    flags_next.tx_empty = empty_lvl;
    flags_next.tx_over = ovr_evt || (flags_reg.tx_over && internal_enable_state && !clr_rd.all);
  end

  // Lock stays until its own clear read or a clear-all read; a new abort re-arms it
  assign abort_lock_next = evt.tx_abort || (abort_lock_reg && !clr_rd.tx_abort && !clr_rd.all);
  assign cause_next = evt.tx_abort ? abort_cause_in :
                      (clr_rd.tx_abort || clr_rd.all) ? `IIS_ABRT_RESET : cause_reg;

  // General call data follows the acknowledge until the next STOP or START
  assign gc_rx_next = evt.gen_call_ack || (gc_rx_reg && !evt.stop_seen && !evt.start_seen);

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      flags_reg <= `IIS_FLAGS_RESET;
      abort_lock_reg <= 1'b0;
      cause_reg <= `IIS_ABRT_RESET;
      gc_rx_reg <= 1'b0;
    end
    else
    begin
      flags_reg <= flags_next;
      abort_lock_reg <= abort_lock_next;
      cause_reg <= cause_next;
      gc_rx_reg <= gc_rx_next;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      rxb_data_reg <= 8'h00;
      rxb_push_reg <= 1'b0;
    end
    else
    begin
      rxb_data_reg <= rx_byte;
      rxb_push_reg <= rx_byte_valid && gc_rx_reg;
    end
  end

  // ==========================================================
  // Status word and outputs
  // ==========================================================
  wire [15:0] raw_word = {4'h0, flags_reg, 3'b000};
  wire [15:0] masked_word = raw_word & intr_mask;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      stat_reg <= `IIS_STAT_RESET;
    else
      stat_reg <= masked_word;
  end

  assign masked_interrupt_status = stat_reg;
  assign abort_cause_reg = cause_reg;
  assign scl_hold_low = flags_reg.rd_req;
  assign rxb_data = rxb_data_reg;
  assign rxb_push = rxb_push_reg;
  assign intr_req = |stat_reg;

endmodule

// *** iis_intr_status_props.sv ***
`timescale 1ns/10ps
// ====
// Port checker for the masked status block
module iis_intr_status_props
  import iis_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Reset
  input wire logic controller_enable_reg, // Enable
  input iis_evt_t evt, // Events
  input wire logic [15:0] abort_cause_in, // Cause in
  input iis_clr_t clr_rd, // Clear reads
  input wire logic [7:0] rx_byte, // Byte in
  input wire logic rx_byte_valid, // Byte strobe
  input wire logic [15:0] intr_mask, // Mask
  input wire logic [15:0] masked_interrupt_status, // Status
  input wire logic [15:0] abort_cause_reg, // Cause out
  input wire logic txf_accept, // Accepted
  input wire logic scl_hold_low, // Stretch
  input wire logic [7:0] rxb_data, // Byte out
  input wire logic rxb_push, // Push
  input wire logic intr_req // Request
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // Enable held so a disable cannot mask a missing set
  property p_set(ev, m, st);
    ev && controller_enable_reg ##1 m && controller_enable_reg |=> st;
  endproperty
  a_gen_call_set: assert property (p_set(evt.gen_call_ack, intr_mask[11], masked_interrupt_status[11]))
    else $error("general call flag missing");
  a_start_set: assert property (p_set(evt.start_seen, intr_mask[10], masked_interrupt_status[10]))
    else $error("start flag missing");
  a_stop_set: assert property (p_set(evt.stop_seen, intr_mask[9], masked_interrupt_status[9]))
    else $error("stop flag missing");
  a_activity_set: assert property (p_set(evt.activity, intr_mask[8], masked_interrupt_status[8]))
    else $error("activity flag missing");
  a_done_set: assert property (p_set(evt.slv_tx_nack, intr_mask[7], masked_interrupt_status[7]))
    else $error("transmit done flag missing");
  a_abort_set: assert property (p_set(evt.tx_abort, intr_mask[6], masked_interrupt_status[6]))
    else $error("abort flag missing");
  a_read_req_set: assert property (p_set(evt.rd_req, intr_mask[5], masked_interrupt_status[5]))
    else $error("read request flag missing");
  a_mask_gate: assert property ((masked_interrupt_status & ~$past(intr_mask)) == 16'h0000)
    else $error("masked bit reported");
  a_reserved_zero: assert property (masked_interrupt_status[15:12] == 4'h0)
    else $error("reserved bits set");
  a_req_any: assert property (intr_req == |masked_interrupt_status)
    else $error("request differs from status");
  a_rd_stretch: assert property (evt.rd_req |=> scl_hold_low)
    else $error("no stretch on read request");
  a_rd_release: assert property (clr_rd.rd_req && !evt.rd_req |=> !scl_hold_low)
    else $error("stretch kept after clear");
  a_abort_lock: assert property (evt.tx_abort |-> !txf_accept ##1 !txf_accept)
    else $error("write taken during abort");
  a_cause_kept: assert property (evt.tx_abort |=> abort_cause_reg == $past(abort_cause_in))
    else $error("abort cause lost");
  a_rx_forward: assert property (rxb_push |-> $past(rx_byte_valid) && rxb_data == $past(rx_byte))
    else $error("wrong byte forwarded");
  c_gen_call: cover property (evt.gen_call_ack ##2 masked_interrupt_status[11]);
  c_rd_req: cover property (evt.rd_req ##1 scl_hold_low);
  c_rx_push: cover property (rxb_push);
endmodule
bind iis_intr_status iis_intr_status_props chk (.*);

// *** iis_intr_status_test.sv ***
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("unexpected %0t %h %h", $time, a, b); \
    end \
  end
// ====
// Bench with reference model: flags, FIFO queue, abort lock
module iis_intr_status_test;
  import iis_pkg::*;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic controller_enable_reg = 1'h0;
  logic fsm_active = 1'h0;
  logic data_command_port_wr = 1'h0;
  logic txf_pop = 1'h0;
  logic stat_rd = 1'h0;
  logic go = 1'h0;
  logic [2:0] kind = 3'h0;
  logic [7:0] byte_in = 8'h00;
  logic [5:0] transmit_threshold_reg = 6'h00;
  logic [15:0] intr_mask = 16'hffff;
  logic [15:0] flags = 16'h0000;
  logic lock = 1'h0;
  iis_clr_t clr_rd = '0;
  iis_evt_t evt;
  logic [15:0] abort_cause_in, masked_interrupt_status, abort_cause_reg;
  logic [7:0] rx_byte, rxb_data, gbyte;
  logic rx_byte_valid, txf_accept, scl_hold_low, rxb_push, intr_req, ok;
  logic [7:0] txq[$];
  int fails = 0;
  int total_checks = 0;
  int npush = 0;
  iis_intr_status uut (.*);
  iis_bus_peer peer (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic fire(int k);
    @(posedge ref_clk);
    kind <= 3'(k);
    byte_in <= 8'($urandom);
    go <= 1'h1;
    @(posedge ref_clk);
    go <= 1'h0;
    flags[k + 5] = 1'h1;
    gbyte = byte_in;
    lock = lock || k == 1;
    if (k == 1)
      txq.delete();
  endtask
  task automatic check_stat();
    repeat (4) @(posedge ref_clk);
    #1;
    flags[4] = controller_enable_reg ? txq.size() <= transmit_threshold_reg : fsm_active;
    `CHK(masked_interrupt_status, flags & intr_mask)
    `CHK(intr_req, |(flags & intr_mask))
  endtask
  task automatic put(int n);
    @(posedge ref_clk);
    data_command_port_wr <= 1'h1;
    repeat (n)
    begin
      #1;
      ok = controller_enable_reg && !lock && txq.size() < 32;
      `CHK(txf_accept, ok)
      flags[3] = flags[3] | (!ok && txq.size() == 32);
      if (ok)
        txq.push_back(8'($urandom));
      @(posedge ref_clk);
    end
    data_command_port_wr <= 1'h0;
  endtask
  task automatic drain(int n);
    @(posedge ref_clk);
    txf_pop <= 1'h1;
    repeat (n)
    begin
      void'(txq.pop_front());
      @(posedge ref_clk);
    end
    txf_pop <= 1'h0;
  endtask
  task automatic clear(logic [4:0] c);
    @(posedge ref_clk);
    clr_rd <= iis_clr_t'(c);
    @(posedge ref_clk);
    clr_rd <= '0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(negedge ref_clk)
    if (rxb_push)
    begin
      npush++;
      `CHK(rxb_data, gbyte)
    end
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    results();
  end
  initial
  begin
    void'($urandom(32'h36d2_79f5));
    repeat (5) @(posedge ref_clk);
    rstn <= 1'h1;
    check_stat();
    $display("reset test done");
    @(posedge ref_clk);
    controller_enable_reg <= 1'h1;
    for (int k = 2; k < 7; k++)
    begin
      fire(k);
      check_stat();
    end
    `CHK(npush, 1)
    clear(5'h10);
    flags[11] = 1'h0;
    check_stat();
    clear(5'h08);
    flags[8] = 1'h0;
    check_stat();
    clear(5'h04);
    flags[10:7] = 4'h0;
    check_stat();
    $display("event test done");
    fire(0);
    // The flag lands one edge after the event pulse, so wait at least one edge
    repeat ($urandom_range(20, 1)) @(posedge ref_clk);
    #1;
    `CHK(scl_hold_low, 1'h1)
    put(1);
    clear(5'h01);
    flags[5] = 1'h0;
    check_stat();
    `CHK(scl_hold_low, 1'h0)
    $display("read request test done");
    @(posedge ref_clk);
    transmit_threshold_reg <= 6'($urandom_range(30));
    intr_mask <= 16'($urandom) | 16'h0118;
    fire(3);
    put(33);
    check_stat();
    drain(31 - transmit_threshold_reg);
    check_stat();
    drain(1);
    check_stat();
    @(posedge ref_clk);
    fsm_active <= 1'h1;
    controller_enable_reg <= 1'h0;
    txq.delete();
    flags[11:6] = 6'h00;
    check_stat();
    @(posedge ref_clk);
    fsm_active <= 1'h0;
    flags[3] = 1'h0;
    check_stat();
    $display("fifo test done");
    @(posedge ref_clk);
    controller_enable_reg <= 1'h1;
    // Zero threshold makes a missed flush show up on the empty flag
    transmit_threshold_reg <= 6'h00;
    put(3);
    fire(1);
    put(1);
    check_stat();
    `CHK(abort_cause_reg, {8'h00, byte_in})
    clear(5'h02);
    {lock, flags[6]} = 2'h0;
    put(2);
    check_stat();
    $display("abort test done");
    results();
  end
endmodule

// *** iis_pkg.sv ***
package iis_pkg;

  // Hardware events from the serial engine, one-cycle pulses
  typedef struct packed {
    logic gen_call_ack;
    logic start_seen;
    logic stop_seen;
    logic activity;
    logic slv_tx_nack;
    logic tx_abort;
    logic rd_req;
  } iis_evt_t;

  // Read strobes of the clear registers, one-cycle pulses
  typedef struct packed {
    logic gen_call;
    logic activity;
    logic all;
    logic tx_abort;
    logic rd_req;
  } iis_clr_t;

  // Flag register order, msb = bit 11 of the status word
  typedef struct packed {
    logic gen_call;
    logic start_seen;
    logic stop_seen;
    logic activity;
    logic tx_done;
    logic tx_abort;
    logic rd_req;
    logic tx_empty;
    logic tx_over;
  } iis_flags_t;

  typedef enum logic [1:0] {
    IIS_RUN = 2'b00,
    IIS_DRAIN = 2'b01,
    IIS_OFF = 2'b11
  } iis_en_state_t;

endpackage

// *** iis_txf_level.sv ***
`timescale 1ns/10ps
`include "iis_cfg.svh"

// Transmit FIFO level counter; data storage lives in the datapath
module iis_txf_level
  import iis_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic flush, // Hold level at zero
  input wire logic push, // Accepted write
  input wire logic pop, // Entry consumed by serial engine
  output logic [`IIS_TXF_LVL_W-1:0] level // Current entries
);

  logic [`IIS_TXF_LVL_W-1:0] level_reg;
  logic [`IIS_TXF_LVL_W-1:0] level_next;
  wire do_pop = pop && (level_reg != `IIS_TXF_ZERO);
  wire do_push = push && (level_reg != `IIS_TXF_FULL);

  assign level_next = flush ? `IIS_TXF_ZERO :
                      (do_push && !do_pop) ? level_reg + `IIS_TXF_ONE :
                      (do_pop && !do_push) ? level_reg - `IIS_TXF_ONE : level_reg;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      level_reg <= `IIS_TXF_ZERO;
    else
      level_reg <= level_next;
  end

  assign level = level_reg;

endmodule
